// ===== bench/analog_front_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Analog side: input mux levels, comparator, RC oscillator
module analog_front_model
	import sar_adc_pkg::*;
(
	// Controls from the sequencer
	input  wire analog_ctrl_type ana,
	// Input levels as ideal codes, per channel and reference
	input  wire logic [3:0][9:0] lvl_supply,
	input  wire logic [3:0][9:0] lvl_ext,
	// Comparator output and dedicated RC oscillator
	output logic                 comp_in,
	output logic                 rc_clock_pin
);
	sample_type level;  // Level seen through the selected path

	// Mux routes the chosen channel, reference scales it
	always_comb begin
		if (ana.ref_ext) begin
			level = lvl_ext[ana.channel];
		end else begin
			level = lvl_supply[ana.channel];
		end
	end

	// An unpowered comparator gives no valid answer, so it
	// toggles with the RC clock instead of holding a value
	always_comb begin
		if (ana.power_on) begin
			// Ideal comparator settles at once, so any period is long
			comp_in = (level >= ana.dac_code);
		end else begin
			comp_in = rc_clock_pin;
		end
	end

	// RC oscillator runs free, phase unrelated to pclk
	initial begin
		rc_clock_pin = 1'b0;
		forever #13 rc_clock_pin = ~rc_clock_pin;
	end
endmodule

`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_consts.svh"

// ==========================================================
// Compare helper: counts every check, reports a mismatch
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
	mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, \
	(g), (e)); end end

module tb_top;
	import sar_adc_pkg::*;

	// ==========================================================
	// Signals
	logic              pclk = 1'b0;   // Bus clock
	logic              presetn;       // Reset, active low
	logic              psel;          // APB select
	logic              penable;       // APB access phase
	logic              pwrite;        // APB direction
	logic [7:0]        paddr;         // APB byte address
	logic [31:0]       pwdata;        // APB write data
	logic              pready;        // APB ready
	logic [31:0]       prdata;        // APB read data
	logic              pslverr;       // APB error
	logic              comp_in;       // Comparator answer
	logic              rc_clock_pin;  // RC oscillator
	analog_ctrl_type   ana;           // Front end controls
	pin_ctrl_type      pins;          // Pin controls
	logic              adc_irq;       // Interrupt
	logic [3:0][9:0]   lvl_supply;    // Channel levels, supply ref
	logic [3:0][9:0]   lvl_ext;       // Channel levels, external ref
	int                mismatches;    // Failed checks
	int                comparisons;   // All checks
	logic [31:0]       rd;            // Last read data
	logic              err;           // Last error response
	int                cyc;           // Cycles to completion
	logic [7:0]        ctl;           // Control value under test
	int                n;             // Divisor under test

	sar_adc_sequencer dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .comp_in(comp_in),
		.rc_clock_pin(rc_clock_pin), .ana(ana), .pins(pins),
		.adc_irq(adc_irq)
	);

	analog_front_model model_u (
		.ana(ana), .lvl_supply(lvl_supply), .lvl_ext(lvl_ext),
		.comp_in(comp_in), .rc_clock_pin(rc_clock_pin)
	);

	// Clock: 100 MHz
	always #5 pclk = ~pclk;

	// ==========================================================
	// Tasks
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 100) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 100) begin
			mismatches++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;  // Let this edge's updates land before checks
	endtask

	// Power is already on: go goes in its own write
	task automatic conv(input logic [7:0] c);
		apb(1'b1, `OFS_CONTROL, {24'h0, c});
		apb(1'b1, `OFS_CONTROL, {24'h0, c | 8'h02});
		cyc = 0;
		while (adc_irq !== 1'b1 && cyc < 3000) begin
			@(posedge pclk);
			#1;
			cyc++;
		end
		if (cyc >= 3000) begin
			mismatches++;
			final_report();
		end
	endtask

	// Result pair against the justify setting
	task automatic chk_result(input sample_type v, input logic j);
		logic [15:0] pair;
		pair = j ? {6'h0, v} : {v, 6'h0};
		apb(1'b0, `OFS_RESULT_HIGH, 32'h0);
		`CHK(rd, {24'h0, pair[15:8]})
		apb(1'b0, `OFS_RESULT_LOW, 32'h0);
		`CHK(rd, {24'h0, pair[7:0]})
	endtask

	task automatic final_report;
		$display("checks %0d, mismatches %0d", comparisons,
			mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog: tests need under 5k cycles, 20k is ample
	initial begin
		#200000;
		mismatches++;
		final_report();
	end

	// ==========================================================
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		comparisons = 0;
		lvl_supply = {10'h15a, 10'h2a5, 10'h000, 10'h3ff};
		lvl_ext = {10'h1ff, 10'h200, 10'h3fe, 10'h001};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		// Reset state and unmapped access
		`CHK({ana.power_on, ana.ref_ext, ana.channel}, 4'h0)
		`CHK(pins, 16'h0)
		apb(1'b0, `OFS_CONTROL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, `OFS_ANALOG_SEL, 32'h0);
		`CHK(rd, 32'h0f)
		apb(1'b0, 8'h20, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		$display("test reset done");
		// Pins: analog on 0 and 2, outputs on 2 and 3, clock /8
		apb(1'b1, `OFS_ANALOG_SEL, 32'h15);
		apb(1'b1, `OFS_PIN_DIR, 32'h3);
		`CHK(pins.digital_in_en, 4'ha)
		`CHK({pins.pullup_allow, pins.change_irq_allow}, 8'haa)
		`CHK(pins.drive_enable, 4'hc)
		$display("test pins done");
		// Go while off, then power-on and go together
		apb(1'b1, `OFS_CONTROL, 32'h02);
		apb(1'b0, `OFS_CONTROL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b1, `OFS_CONTROL, 32'h03);
		apb(1'b0, `OFS_CONTROL, 32'h0);
		`CHK(rd, 32'h01)
		`CHK(ana.power_on, 1'b1)
		$display("test power done");
		// Every channel, both references, both formats
		apb(1'b1, `OFS_IRQ_ENABLE, 32'h40);
		for (int i = 0; i < 8; i++) begin
			ctl = {i[0] ^ i[2], i[2], 2'b00, i[1:0], 2'b01};
			conv(ctl);
			`CHK({ana.channel, ana.ref_ext}, {i[1:0], i[2]})
			chk_result(i[2] ? lvl_ext[i[1:0]] : lvl_supply[i[1:0]],
				ctl[7]);
			apb(1'b0, `OFS_CONTROL, 32'h0);
			`CHK(rd, {24'h0, ctl})
			apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
			`CHK(rd, 32'h40)
			apb(1'b1, `OFS_IRQ_CLEAR, 32'h40);
			apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
			`CHK({rd[6], adc_irq}, 2'b00)
		end
		// Interrupt masked and unmasked with flag standing
		conv(8'h01);
		apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
		`CHK({rd[6], adc_irq}, 2'b10)
		apb(1'b1, `OFS_IRQ_ENABLE, 32'h40);
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
		`CHK(adc_irq, 1'b1)
		apb(1'b1, `OFS_IRQ_CLEAR, 32'h40);
		$display("test conversions done");
		// Duration for every clock code; channel 0 stays 3ff
		for (int k = 0; k < 8; k++) begin
			n = 2 << k;
			apb(1'b1, `OFS_ANALOG_SEL,
				{25'h0, k[0], k[2], k[1], 4'h5});
			if (k > 5) begin
				apb(1'b1, `OFS_ANALOG_SEL,
					{25'h0, k[0], 2'b11, 4'h5});
			end
			conv(8'h01);
			if (k > 5) begin
				`CHK(cyc >= 25 && cyc <= 40, 1'b1)
			end else begin
				`CHK(cyc >= 11 * n - 2 && cyc <= 12 * n + 8, 1'b1)
			end
			chk_result(10'h3ff, 1'b0);
			apb(1'b1, `OFS_IRQ_CLEAR, 32'h40);
		end
		$display("test clock codes done");
		// Abort mid-conversion at /8, channel 1 right justified
		apb(1'b1, `OFS_ANALOG_SEL, 32'h15);
		conv_abort: begin
			apb(1'b1, `OFS_CONTROL, 32'h85);
			apb(1'b1, `OFS_CONTROL, 32'h87);
			repeat (30) @(posedge pclk);
			apb(1'b1, `OFS_CONTROL, 32'h85);
			// Two whole periods at /8 have not yet passed here
			repeat (15) @(posedge pclk);
			#1;
			`CHK(ana.track, 1'b0)
			repeat (30) @(posedge pclk);
			#1;
			`CHK(ana.track, 1'b1)
		end
		apb(1'b0, `OFS_CONTROL, 32'h0);
		`CHK(rd, 32'h85)
		chk_result(10'h3ff, 1'b0);
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		$display("test abort done");
		final_report();
	end
endmodule

`default_nettype wire

// ===== hdl/conv_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none

module conv_clock_gen (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] clock_code,
	// Dedicated RC oscillator pin
	input  wire logic       rc_clock_pin,
	// One-cycle pulse at the end of each conversion clock period
	output logic            tick
);

	// ==========================================================
	// Divider decode
	function automatic logic [6:0] div_of(input logic [2:0] code);
		unique case (code)
			3'h0:    div_of = 7'h02;
			3'h4:    div_of = 7'h04;
			3'h1:    div_of = 7'h08;
			3'h5:    div_of = 7'h10;
			3'h2:    div_of = 7'h20;
			3'h6:    div_of = 7'h40;
			default: div_of = 7'h02; // RC codes do not use the divider
		endcase
	endfunction

	logic       rc_meta;  // First synchroniser stage
	logic       rc_sync;  // Second synchroniser stage
	logic       rc_last;  // Previous synchronised level
	logic [6:0] cnt;      // Bus clock divider
	logic       rc_mode;  // Any x11 code picks the RC source
	logic       div_end;  // Divider wraps this cycle

	assign rc_mode = (clock_code[1:0] == 2'h3);
	assign div_end = (cnt == div_of(clock_code) - 7'h01);

	// ==========================================================
	// RC pin synchroniser; edges are taken past the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_meta <= 1'b0;
			rc_sync <= 1'b0;
			rc_last <= 1'b0;
		end else begin
			rc_meta <= rc_clock_pin;
			rc_sync <= rc_meta;
			rc_last <= rc_sync;
		end
	end

	// Divider is held clear while idle so every period starts whole
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt <= 7'h00;
		else if (!run || div_end)
			cnt <= 7'h00;
		else
			cnt <= cnt + 7'h01;
	end

	// Registered period strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick <= 1'b0;
		else
			tick <= run & (rc_mode ? (rc_sync & ~rc_last) : div_end);
	end

endmodule

`default_nettype wire

// ===== hdl/sar_adc_consts.svh
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_CONTROL      8'h00
`define OFS_ANALOG_SEL   8'h04
`define OFS_PIN_DIR      8'h08
`define OFS_RESULT_HIGH  8'h0c
`define OFS_RESULT_LOW   8'h10
`define OFS_IRQ_STATUS   8'h14
`define OFS_IRQ_CLEAR    8'h18
`define OFS_IRQ_ENABLE   8'h1c

// ==========================================================
// Field positions
`define CTL_POWER        0
`define CTL_GO           1
`define CTL_CHAN_LSB     2
`define CTL_REF          6
`define CTL_JUSTIFY      7
`define SEL_CLK_LSB      4
`define FLAG_DONE        6

// ==========================================================
// Reset values and writable masks
`define CONTROL_RST      8'h00
`define CONTROL_MASK     8'hcf
`define ANALOG_SEL_RST   8'h0f
`define ANALOG_SEL_MASK  8'h7f
`define PIN_DIR_RST      4'hf
`define IRQ_ENABLE_RST   8'h00
`define IRQ_MASK         8'h40

// ==========================================================
// Timing counts in conversion clock periods
`define CONV_TADS        11
`define HOLDOFF_TADS     2

`endif

// ===== hdl/sar_adc_pkg.sv
package sar_adc_pkg;

	// ==========================================================
	// Types shared by the sequencer and its environment
	localparam int RESULT_BITS = 10;

	typedef logic [RESULT_BITS-1:0] sample_type;

	// Sequencer states
	typedef enum logic [1:0] {
		st_idle,
		st_convert,
		st_holdoff
	} seq_state_type;

	// Controls toward the analog front end
	typedef struct packed {
		logic       power_on;   // Converter bias on
		logic       ref_ext;    // 1: external reference pin
		logic [1:0] channel;    // Mux input to sample-and-hold
		logic       track;      // Sample-and-hold tracking input
		sample_type dac_code;   // Trial code for the comparator
	} analog_ctrl_type;

	// Per-pin port controls, one bit per analog-capable pin
	typedef struct packed {
		logic [3:0] digital_in_en;    // Digital input buffer on
		logic [3:0] pullup_allow;     // Weak pull-up may act
		logic [3:0] change_irq_allow; // Change detect may act
		logic [3:0] drive_enable;     // Output driver on
	} pin_ctrl_type;

endpackage

// ===== hdl/sar_adc_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_consts.svh"

module sar_adc_sequencer
	import sar_adc_pkg::*;
#(
	parameter int CONV_TADS    = `CONV_TADS,
	parameter int HOLDOFF_TADS = `HOLDOFF_TADS
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic               pready,
	output logic [31:0]        prdata,
	output logic               pslverr,
	// Analog front end
	input  wire logic          comp_in,
	input  wire logic          rc_clock_pin,
	output var analog_ctrl_type ana,
	// Port pins
	output var pin_ctrl_type   pins,
	// Interrupt
	output logic               adc_irq
);

	// ==========================================================
	// Elaboration checks
	generate
		if (CONV_TADS < RESULT_BITS + 1 || CONV_TADS > 16) begin : bad_tads
			$error("CONV_TADS must lie between 11 and 16");
		end
		if (HOLDOFF_TADS < 1 || HOLDOFF_TADS > 16) begin : bad_hold
			$error("HOLDOFF_TADS must lie between 1 and 16");
		end
	endgenerate

	localparam logic [3:0] LAST_TAD   = 4'(CONV_TADS - 1);
	localparam logic [3:0] FIRST_BIT  = 4'(CONV_TADS - RESULT_BITS);
	localparam logic [3:0] LAST_HOLD  = 4'(HOLDOFF_TADS - 1);
	localparam sample_type TOP_BIT    = sample_type'(1) << (RESULT_BITS-1);

	// ==========================================================
	// Functions
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `OFS_CONTROL)     || (a == `OFS_ANALOG_SEL) ||
		            (a == `OFS_PIN_DIR)     || (a == `OFS_RESULT_HIGH) ||
		            (a == `OFS_RESULT_LOW)  || (a == `OFS_IRQ_STATUS) ||
		            (a == `OFS_IRQ_CLEAR)   || (a == `OFS_IRQ_ENABLE);
	endfunction

	// Keep or drop the trial bit, then try the next one down
	function automatic sample_type resolve(input sample_type code,
	                                      input sample_type mask,
	                                      input logic       high);
		resolve = (high ? code : (code & ~mask)) | (mask >> 1);
	endfunction

	// ==========================================================
	// Registers and state
	logic [7:0]    control;      // Converter control
	logic [7:0]    analog_sel;   // Clock code and analog pin select
	logic [3:0]    pin_dir;      // 1 = pin is input
	logic [15:0]   result_pair;  // High and low result bytes
	logic          done_flag;    // Sticky completion flag
	logic [7:0]    irq_enable;   // Interrupt enable, same layout
	seq_state_type state;        // Sequencer state
	logic [3:0]    tad_count;    // Periods seen in this phase
	sample_type    sar_code;     // Trial code under test
	sample_type    bit_mask;     // Bit being decided
	logic          comp_meta;    // First comparator sync stage
	logic          comp_high;    // Comparator: input above trial
	logic          tick;         // End of a conversion clock period

	logic        wr_access;      // APB write access phase
	logic        setup;          // APB setup phase
	logic        power_on;       // Converter enabled
	logic        go;             // Go/done bit
	logic        done;           // Conversion completes this cycle
	sample_type  final_code;     // Value after the last decision

	assign power_on   = control[`CTL_POWER];
	assign go         = control[`CTL_GO];
	assign wr_access  = psel & penable & pwrite;
	assign setup      = psel & ~penable;
	assign final_code = resolve(sar_code, bit_mask, comp_high);
	assign done       = (state == st_convert) & go & tick &
	                    (tad_count == LAST_TAD);

	// ==========================================================
	// APB answer: no wait states, unmapped access flags an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~is_mapped(paddr);

	// Read data is captured in setup so it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			unique case (paddr)
				`OFS_CONTROL:     prdata <= {24'h0, control};
				`OFS_ANALOG_SEL:  prdata <= {24'h0, analog_sel};
				`OFS_PIN_DIR:     prdata <= {28'h0, pin_dir};
				`OFS_RESULT_HIGH: prdata <= {24'h0, result_pair[15:8]};
				`OFS_RESULT_LOW:  prdata <= {24'h0, result_pair[7:0]};
				`OFS_IRQ_STATUS:  prdata <= {24'h0, 1'b0, done_flag, 6'h0};
				`OFS_IRQ_ENABLE:  prdata <= {24'h0, irq_enable};
				// Clear register is write-only; unmapped reads zero
				default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Control register with hardware-managed go bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control <= `CONTROL_RST;
		end else if (done) begin
			// Completion beats a same-cycle write of go
			control[`CTL_GO] <= 1'b0;
			if (wr_access && paddr == `OFS_CONTROL) begin
				control[`CTL_JUSTIFY] <= pwdata[`CTL_JUSTIFY];
				control[`CTL_REF]     <= pwdata[`CTL_REF];
				control[3:2]          <= pwdata[3:2];
				control[`CTL_POWER]   <= pwdata[`CTL_POWER];
			end
		end else if (wr_access && paddr == `OFS_CONTROL) begin
			control <= pwdata[7:0] & `CONTROL_MASK;
			// Go counts only if already powered and not holding off
			control[`CTL_GO] <= pwdata[`CTL_GO] & power_on &
			                    pwdata[`CTL_POWER] &
			                    (state != st_holdoff);
		end
	end

	// Other configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_sel <= `ANALOG_SEL_RST;
			pin_dir    <= `PIN_DIR_RST;
			irq_enable <= `IRQ_ENABLE_RST;
		end else if (wr_access) begin
			if (paddr == `OFS_ANALOG_SEL)
				analog_sel <= pwdata[7:0] & `ANALOG_SEL_MASK;
			if (paddr == `OFS_PIN_DIR)
				pin_dir <= pwdata[3:0];
			if (paddr == `OFS_IRQ_ENABLE)
				irq_enable <= pwdata[7:0] & `IRQ_MASK;
		end
	end

	// ==========================================================
	// Completion flag: a new completion wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			done_flag <= 1'b0;
		else if (done)
			done_flag <= 1'b1;
		else if (wr_access && paddr == `OFS_IRQ_CLEAR &&
		         pwdata[`FLAG_DONE])
			done_flag <= 1'b0;
	end

	// Level interrupt while an enabled flag is set
	assign adc_irq = done_flag & irq_enable[`FLAG_DONE];

	// ==========================================================
	// Comparator synchroniser; the trial code settles for a whole
	// period before it is judged, so two stages add no error when a period lasts three or more pclk cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_meta <= 1'b0;
			comp_high <= 1'b0;
		end else begin
			comp_meta <= comp_in;
			comp_high <= comp_meta;
		end
	end

	// Conversion clock source and divider; the divider is cleared
	// in the abort cycle so the hold-off counts whole periods
	conv_clock_gen u_clock (
		.pclk         (pclk),
		.presetn      (presetn),
		.run          (power_on && state != st_idle &&
		               !(state == st_convert && !go)),
		.clock_code   (analog_sel[6:4]),
		.rc_clock_pin (rc_clock_pin),
		.tick         (tick)
	);

	// ==========================================================
	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= st_idle;
			tad_count <= 4'h0;
			sar_code  <= TOP_BIT;
			bit_mask  <= TOP_BIT;
		end else if (!power_on) begin
			// Powered down: nothing runs
			state     <= st_idle;
			tad_count <= 4'h0;
		end else begin
			unique case (state)
				st_idle: begin
					tad_count <= 4'h0;
					sar_code  <= TOP_BIT;
					bit_mask  <= TOP_BIT;
					if (go)
						state <= st_convert;
				end
				st_convert: begin
					if (!go) begin
						// Software abort
						state     <= st_holdoff;
						tad_count <= 4'h0;
					end else if (tick) begin
						if (tad_count == LAST_TAD)
							state <= st_idle;
						tad_count <= tad_count + 4'h1;
						// First periods hold the sample, the rest decide bits
						if (tad_count >= FIRST_BIT) begin
							sar_code <= final_code;
							bit_mask <= bit_mask >> 1;
						end
					end
				end
				st_holdoff: begin
					if (tick) begin
						if (tad_count == LAST_HOLD)
							state <= st_idle;
						tad_count <= tad_count + 4'h1;
					end
				end
			endcase
		end
	end

	// Result pair updated only at completion; aborts leave it alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			result_pair <= 16'h0000;
		else if (done) begin
			if (control[`CTL_JUSTIFY])
				result_pair <= {6'h00, final_code};
			else
				result_pair <= {final_code, 6'h00};
		end
	end

	// ==========================================================
	// Analog and pin controls
	assign ana.power_on = power_on;
	assign ana.ref_ext  = control[`CTL_REF];
	assign ana.channel  = control[3:2];
	// Tracking in idle means acquisition restarts after a hold-off
	assign ana.track    = power_on & (state == st_idle);
	assign ana.dac_code = sar_code;

	// Analog pins lose the digital buffer, pull-up and change detect
	assign pins.digital_in_en    = ~analog_sel[3:0];
	assign pins.pullup_allow     = ~analog_sel[3:0];
	assign pins.change_irq_allow = ~analog_sel[3:0];
	assign pins.drive_enable     = ~pin_dir;

	// ==========================================================
	// Checks
	logic [3:0] conv_ticks; // Ticks seen since the conversion began

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			conv_ticks <= 4'h0;
		else if (state != st_convert)
			conv_ticks <= 4'h0;
		else if (tick)
			conv_ticks <= conv_ticks + 4'h1;
	end

	chk_conv_length: assert property (
		@(posedge pclk) disable iff (!presetn)
		done |-> conv_ticks == LAST_TAD)
		else $error("conversion did not take eleven periods");

	chk_done_clears_go: assert property (
		@(posedge pclk) disable iff (!presetn)
		done |=> !go && done_flag && state == st_idle)
		else $error("completion did not clear go and set flag");

	chk_irq_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		done && irq_enable[`FLAG_DONE] |=> adc_irq)
		else $error("enabled completion raised no interrupt");

	chk_start_conv: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == st_idle && go && power_on |=> state == st_convert)
		else $error("go did not start a conversion");

	chk_abort_keeps: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == st_convert && !go && power_on |=>
		state == st_holdoff && $stable(result_pair))
		else $error("abort changed the result or missed hold-off");

	chk_holdoff_end: assert property (
		@(posedge pclk) disable iff (!presetn)
		state == st_holdoff && power_on && tick &&
		tad_count == LAST_HOLD |=> ana.track)
		else $error("acquisition did not restart after hold-off");

	chk_right_just: assert property (
		@(posedge pclk) disable iff (!presetn)
		done && control[`CTL_JUSTIFY] |=> result_pair[15:10] == 6'h00)
		else $error("right-justified result has upper bits set");

	chk_left_just: assert property (
		@(posedge pclk) disable iff (!presetn)
		done && !control[`CTL_JUSTIFY] |=> result_pair[5:0] == 6'h00)
		else $error("left-justified result has lower bits set");

	chk_power_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		!power_on |-> !ana.track ##1 state == st_idle)
		else $error("converter active while powered down");

endmodule

`default_nettype wire
